// ===== pkg/rau_consts.vh
// Purpose: Shared constants of the two-channel line-direction serial port.
// Assumes: Included by bare name from the design files; definitions only.
// Notes:   Offsets are byte addresses on the 32-bit register bus.
//
// Behaviour
// (R1) RS-485: driver on when transmit data waits
// (R2) Driver held one character after last stop
// (R3) Hold time follows programmed baud divisor
// (R4) RS-485 receiver blanked while driving line
// (R5) Sixteen-byte transmit and receive queues
// (R6) Base clock range reaches standard rates
// (R7) Quad clock select multiplies clock by four
// (R8) Software keeps gate bit low to communicate
// (R9) RS-485 is half duplex, one direction
// (R10) RS-422 driver always on, full duplex
// (R11) Each channel is RS-422 or RS-485
// (R12) Five-eight bits, parity, one-two stop bits
`ifndef RAU_CONSTS_VH
`define RAU_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define RAU_OFF_DATA 12'h000
`define RAU_OFF_DIV 12'h004
`define RAU_OFF_LINE 12'h008
`define RAU_OFF_STAT 12'h00c
`define RAU_CH_STRIDE 12'h020
`define RAU_CH_BIT 5

// ****************************************
// Line control fields
// ****************************************
`define RAU_LC_BITS_LO 0
`define RAU_LC_BITS_HI 1
`define RAU_LC_PAR_EN 2
`define RAU_LC_PAR_EVEN 3
`define RAU_LC_STOP_LO 4
`define RAU_LC_STOP_HI 5
`define RAU_LC_RS485 6
`define RAU_LC_QUAD 7
`define RAU_LC_GATE 8
`define RAU_LC_BLANK 9
`define RAU_LINE_RST 10'h203
`define RAU_DIV_RST 16'h0004

// ****************************************
// Status fields and timing
// ****************************************
`define RAU_ST_W1C_MASK 8'he0
`define RAU_OVS_TICKS 6'h10
`define RAU_HALF_TICKS 6'h08
`define RAU_QUAD_FACTOR 3'h4
`define RAU_FIFO_DEPTH 5'h10

`endif

// ===== core/rau_fifo.v
// Purpose: Sixteen-entry byte queue with valid/ready on both sides.
// Assumes: Single clock; storage in flip-flops indexed by pointer.
// Notes:   Storage itself is not reset; only pointers and count are.
`default_nettype none
`include "rau_consts.vh"
module rau_fifo (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   input wire [7:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [7:0] out_data,
   input wire out_ready
);
   reg [7:0] mem_reg [0:15];
   reg [3:0] wr_reg;
   reg [3:0] rd_reg;
   reg [4:0] cnt_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (cnt_reg != `RAU_FIFO_DEPTH); // R5
   assign out_valid = (cnt_reg != 5'h00);
   assign out_data = mem_reg[rd_reg];

   always @(posedge pclk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_reg <= 4'h0;
         rd_reg <= 4'h0;
         cnt_reg <= 5'h00;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 4'h1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 4'h1;
         end
         if (push & ~pop) begin
            cnt_reg <= cnt_reg + 5'h01;
         end else if (pop & ~push) begin
            cnt_reg <= cnt_reg - 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/rau_skid.v
// Purpose: Two-entry buffer between transmit queue and shifter.
// Assumes: Single clock; full throughput with registered ready.
// Notes:   A stall by the shifter never drops a word already taken.
`default_nettype none
module rau_skid (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   input wire [7:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [7:0] out_data,
   input wire out_ready
);
   reg [7:0] d0_reg;
   reg [7:0] d1_reg;
   reg [1:0] cnt_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = d0_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d0_reg <= 8'h00;
         d1_reg <= 8'h00;
         cnt_reg <= 2'h0;
      end else if (pop & ~push) begin
         d0_reg <= d1_reg;
         cnt_reg <= cnt_reg - 2'h1;
      end else if (push & ~pop) begin
         if (cnt_reg == 2'h0) begin
            d0_reg <= in_data;
         end else begin
            d1_reg <= in_data;
         end
         cnt_reg <= cnt_reg + 2'h1;
      end else if (push & pop) begin
         if (cnt_reg == 2'h1) begin
            d0_reg <= in_data;
         end else begin
            d0_reg <= d1_reg;
            d1_reg <= in_data;
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/rau_top.v
// Purpose: Two serial channels with automatic RS-485 driver direction.
// Assumes: APB slave on pclk; line pins are asynchronous to pclk.
// Notes:   Each channel has data, divisor, line control and status words.
`default_nettype none
`include "rau_consts.vh"
module rau_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [1:0] rxd,
   output wire [1:0] txd,
   output wire [1:0] drive_en,
   output wire [1:0] rx_en
);
   // ****************************************
   // Bus slave
   // ****************************************
   localparam TX_IDLE = 3'h0;
   localparam TX_START = 3'h1;
   localparam TX_DATA = 3'h2;
   localparam TX_PAR = 3'h3;
   localparam TX_STOP = 3'h4;
   localparam TX_HOLD = 3'h5;
   localparam RX_IDLE = 3'h0;
   localparam RX_START = 3'h1;
   localparam RX_DATA = 3'h2;
   localparam RX_PAR = 3'h3;
   localparam RX_STOP = 3'h4;

   reg [31:0] prdata_reg;
   reg pready_reg;
   reg pslverr_reg;
   wire [31:0] ch_rd [0:1];
   wire [11:0] roff = paddr & ~`RAU_CH_STRIDE;
   wire hit = (roff == `RAU_OFF_DATA) | (roff == `RAU_OFF_DIV) |
              (roff == `RAU_OFF_LINE) | (roff == `RAU_OFF_STAT);
   wire access = psel & penable & ~pready_reg;
   wire done = psel & penable & pready_reg;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // One wait state: read data is captured before the completing edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access & ~hit;
         if (access) begin
            prdata_reg <= (hit & ~pwrite) ? ch_rd[paddr[`RAU_CH_BIT]] : 32'h00000000;
         end
      end
   end

   // ****************************************
   // Channels
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         reg [15:0] div_reg;
         reg [9:0] line_reg;
         reg [1:0] pre_reg;
         reg [15:0] bcnt_reg;
         reg tick_reg;
         reg [2:0] ts_reg;
         reg [5:0] tcnt_reg;
         reg [2:0] tbit_reg;
         reg [7:0] tsh_reg;
         reg tpar_reg;
         reg txd_reg;
         reg [9:0] hold_reg;
         reg de_reg;
         reg rxen_reg;
         reg rs1_reg;
         reg rs2_reg;
         reg [2:0] rs_reg;
         reg [5:0] rcnt_reg;
         reg [2:0] rbit_reg;
         reg [7:0] rsh_reg;
         reg rpar_reg;
         reg rpush_reg;
         reg [7:0] rdat_reg;
         reg ovr_reg;
         reg perr_reg;
         reg ferr_reg;
         wire sel = (paddr[`RAU_CH_BIT] == g) & hit;
         wire wr = done & pwrite & sel;
         wire rd = done & ~pwrite & sel;
         wire [3:0] nbits = {2'b00, line_reg[`RAU_LC_BITS_HI:`RAU_LC_BITS_LO]} + 4'h5;
         wire par_en = line_reg[`RAU_LC_PAR_EN];
         wire even = line_reg[`RAU_LC_PAR_EVEN];
         wire rs485 = line_reg[`RAU_LC_RS485];
         wire gate = line_reg[`RAU_LC_GATE];
         wire [1:0] stop_sel = line_reg[`RAU_LC_STOP_HI:`RAU_LC_STOP_LO];
         wire [5:0] stop_ticks = (stop_sel == 2'h0) ? `RAU_OVS_TICKS :
                                 (stop_sel == 2'h1) ? (`RAU_OVS_TICKS + `RAU_HALF_TICKS) :
                                 (`RAU_OVS_TICKS + `RAU_OVS_TICKS); // R12
         wire [9:0] char_ticks = {2'b00, 4'h1 + nbits + {3'h0, par_en}, 4'h0} +
                                 {4'h0, stop_ticks}; // R3
         wire [15:0] div_m1 = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
         wire base_ok = line_reg[`RAU_LC_QUAD] |
                        ({1'b0, pre_reg} == (`RAU_QUAD_FACTOR - 3'h1)); // R7
         wire f_in_ready;
         wire f_out_valid;
         wire [7:0] f_out_data;
         wire s_in_ready;
         wire s_out_valid;
         wire [7:0] s_out_data;
         wire r_in_ready;
         wire r_out_valid;
         wire [7:0] r_out_data;
         wire tx_take = tick_reg & ~gate & s_out_valid &
                        ((ts_reg == TX_IDLE) | (ts_reg == TX_HOLD)); // R8
         wire waiting = ~gate & (f_out_valid | s_out_valid);
         wire de_next = rs485 ? (waiting | (ts_reg != TX_IDLE)) : 1'b1; // R1 R2 R9 R10 R11
         wire rxin = rs2_reg | ~rxen_reg;
         wire [7:0] rx_word = rsh_reg >> (4'h8 - nbits);
         wire [7:0] stat = {ferr_reg, perr_reg, ovr_reg, rxen_reg, de_reg,
                            (ts_reg == TX_IDLE) & ~s_out_valid & ~f_out_valid,
                            ~f_in_ready, r_out_valid};
         wire [7:0] w1c = pwdata[7:0] & `RAU_ST_W1C_MASK;
         wire clr = wr & (roff == `RAU_OFF_STAT);
         wire rx_bad = (rs_reg == RX_STOP) & tick_reg & (rcnt_reg == 6'h0f);

         assign ch_rd[g] = (roff == `RAU_OFF_DATA) ? {24'h000000, r_out_data} :
                           (roff == `RAU_OFF_DIV) ? {16'h0000, div_reg} :
                           (roff == `RAU_OFF_LINE) ? {22'h000000, line_reg} :
                           {24'h000000, stat};
         assign txd[g] = txd_reg;
         assign drive_en[g] = de_reg;
         assign rx_en[g] = rxen_reg;

         rau_fifo u_txq (
            .pclk(pclk),
            .presetn(presetn),
            .in_valid(wr & (roff == `RAU_OFF_DATA)),
            .in_data(pwdata[7:0]),
            .in_ready(f_in_ready),
            .out_valid(f_out_valid),
            .out_data(f_out_data),
            .out_ready(s_in_ready)
         ); // R5
         rau_skid u_skid (
            .pclk(pclk),
            .presetn(presetn),
            .in_valid(f_out_valid),
            .in_data(f_out_data),
            .in_ready(s_in_ready),
            .out_valid(s_out_valid),
            .out_data(s_out_data),
            .out_ready(tx_take)
         );
         rau_fifo u_rxq (
            .pclk(pclk),
            .presetn(presetn),
            .in_valid(rpush_reg),
            .in_data(rdat_reg),
            .in_ready(r_in_ready),
            .out_valid(r_out_valid),
            .out_data(r_out_data),
            .out_ready(rd & (roff == `RAU_OFF_DATA))
         ); // R5

         // Registers, baud tick and sticky error flags; a set beats a clear
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               div_reg <= `RAU_DIV_RST;
               line_reg <= `RAU_LINE_RST;
               pre_reg <= 2'h0;
               bcnt_reg <= 16'h0000;
               tick_reg <= 1'b0;
               ovr_reg <= 1'b0;
               perr_reg <= 1'b0;
               ferr_reg <= 1'b0;
               de_reg <= 1'b0;
               rxen_reg <= 1'b1;
               rs1_reg <= 1'b1;
               rs2_reg <= 1'b1;
            end else begin
               if (wr & (roff == `RAU_OFF_DIV)) begin
                  div_reg <= pwdata[15:0];
               end
               if (wr & (roff == `RAU_OFF_LINE)) begin
                  line_reg <= pwdata[9:0];
               end
               pre_reg <= pre_reg + 2'h1;
               tick_reg <= 1'b0;
               if (base_ok) begin
                  if (bcnt_reg >= div_m1) begin
                     bcnt_reg <= 16'h0000;
                     tick_reg <= 1'b1; // R6
                  end else begin
                     bcnt_reg <= bcnt_reg + 16'h0001;
                  end
               end
               ovr_reg <= (rpush_reg & ~r_in_ready) | (ovr_reg & ~(clr & w1c[5]));
               perr_reg <= (rx_bad & par_en & rpar_reg) | (perr_reg & ~(clr & w1c[6]));
               ferr_reg <= (rx_bad & ~rxin) | (ferr_reg & ~(clr & w1c[7]));
               de_reg <= de_next;
               rxen_reg <= ~(rs485 & line_reg[`RAU_LC_BLANK] & de_next); // R4
               rs1_reg <= rxd[g];
               rs2_reg <= rs1_reg;
            end
         end

         // Transmitter and driver hold
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ts_reg <= TX_IDLE;
               tcnt_reg <= 6'h00;
               tbit_reg <= 3'h0;
               tsh_reg <= 8'h00;
               tpar_reg <= 1'b0;
               txd_reg <= 1'b1;
               hold_reg <= 10'h000;
            end else if (tx_take) begin
               ts_reg <= TX_START;
               tcnt_reg <= 6'h00;
               tsh_reg <= s_out_data;
               tpar_reg <= 1'b0;
               txd_reg <= 1'b0;
            end else if (tick_reg) begin
               tcnt_reg <= tcnt_reg + 6'h01;
               case (ts_reg)
                  TX_START: begin
                     if (tcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                        ts_reg <= TX_DATA;
                        tcnt_reg <= 6'h00;
                        tbit_reg <= 3'h0;
                        txd_reg <= tsh_reg[0];
                     end
                  end
                  TX_DATA: begin
                     if (tcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                        tcnt_reg <= 6'h00;
                        tpar_reg <= tpar_reg ^ tsh_reg[0];
                        tsh_reg <= {1'b0, tsh_reg[7:1]};
                        tbit_reg <= tbit_reg + 3'h1;
                        if ({1'b0, tbit_reg} == nbits - 4'h1) begin
                           ts_reg <= par_en ? TX_PAR : TX_STOP;
                           txd_reg <= par_en ? (tpar_reg ^ tsh_reg[0] ^ ~even) : 1'b1;
                        end else begin
                           txd_reg <= tsh_reg[1];
                        end
                     end
                  end
                  TX_PAR: begin
                     if (tcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                        ts_reg <= TX_STOP;
                        tcnt_reg <= 6'h00;
                        txd_reg <= 1'b1;
                     end
                  end
                  TX_STOP: begin
                     if (tcnt_reg == stop_ticks - 6'h01) begin
                        ts_reg <= rs485 ? TX_HOLD : TX_IDLE;
                        hold_reg <= 10'h000;
                     end
                  end
                  TX_HOLD: begin
                     // The pair stays driven one character time at the current rate
                     hold_reg <= hold_reg + 10'h001;
                     if (hold_reg == char_ticks - 10'h001) begin
                        ts_reg <= TX_IDLE; // R2 R3
                     end
                  end
                  default: begin
                     ts_reg <= TX_IDLE;
                  end
               endcase
            end
         end

         // Receiver with mid-bit sampling on the sixteen-times tick
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rs_reg <= RX_IDLE;
               rcnt_reg <= 6'h00;
               rbit_reg <= 3'h0;
               rsh_reg <= 8'h00;
               rpar_reg <= 1'b0;
               rpush_reg <= 1'b0;
               rdat_reg <= 8'h00;
            end else begin
               rpush_reg <= 1'b0;
               if (tick_reg) begin
                  rcnt_reg <= rcnt_reg + 6'h01;
                  case (rs_reg)
                     RX_IDLE: begin
                        rcnt_reg <= 6'h00;
                        if (~rxin) begin
                           rs_reg <= RX_START;
                        end
                     end
                     RX_START: begin
                        if (rcnt_reg == `RAU_HALF_TICKS - 6'h01) begin
                           rcnt_reg <= 6'h00;
                           rbit_reg <= 3'h0;
                           rpar_reg <= ~even;
                           rs_reg <= rxin ? RX_IDLE : RX_DATA;
                        end
                     end
                     RX_DATA: begin
                        if (rcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                           rcnt_reg <= 6'h00;
                           rsh_reg <= {rxin, rsh_reg[7:1]};
                           rpar_reg <= rpar_reg ^ rxin;
                           rbit_reg <= rbit_reg + 3'h1;
                           if ({1'b0, rbit_reg} == nbits - 4'h1) begin
                              rs_reg <= par_en ? RX_PAR : RX_STOP;
                           end
                        end
                     end
                     RX_PAR: begin
                        if (rcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                           rcnt_reg <= 6'h00;
                           rpar_reg <= rpar_reg ^ rxin;
                           rs_reg <= RX_STOP;
                        end
                     end
                     RX_STOP: begin
                        if (rcnt_reg == `RAU_OVS_TICKS - 6'h01) begin
                           rs_reg <= RX_IDLE;
                           rpush_reg <= 1'b1;
                           rdat_reg <= rx_word; // R12
                        end
                     end
                     default: begin
                        rs_reg <= RX_IDLE;
                     end
                  endcase
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== verification/rau_checker.sv
// Purpose: Port-level checks of bus timing and line direction.
// Assumes: Bound to rau_top; channel 0 carries the direction checks.
// Notes:   Hold time is checked against the shortest legal character.
`default_nettype none
module rau_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] rxd,
   input wire logic [1:0] txd,
   input wire logic [1:0] drive_en,
   input wire logic [1:0] rx_en
);
   timeunit 1ns;
   timeprecision 1ns;
   int hi_cnt;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // *****
   // Idle-line counter
   // *****
   // Saturates so a long idle line cannot wrap below the minimum
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= 0;
      end else if (!txd[0]) begin
         hi_cnt <= 0;
      end else if (hi_cnt < 1000) begin
         hi_cnt <= hi_cnt + 1;
      end
   end
   AST_ACCESS_WAIT: assert property ((psel && !penable) ##1 (psel && penable)
      |-> !pready ##1 pready) else $error("pready not in second access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_SETUP_NO_READY: assert property ((psel && !penable) |-> !pready)
      else $error("pready in setup cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_WRITE_ZERO_DATA: assert property ((pready && pwrite) |-> prdata == 32'h0)
      else $error("read data not zero on write");
   AST_BLANK_ONLY_DRIVING: assert property ((~rx_en & ~drive_en) == 2'h0)
      else $error("receiver off while driver off");
   AST_START_WHILE_DRIVING: assert property ($fell(txd[0]) |-> drive_en[0])
      else $error("start bit with driver off");
   AST_HOLD_ONE_CHAR: assert property ($fell(drive_en[0]) |-> hi_cnt >= 112)
      else $error("driver released too early");
   AST_START_MIN_WIDTH: assert property ($fell(txd[0]) |-> (!txd[0]) [*8])
      else $error("start bit too short");
   AST_IDLE_RELEASED: assert property (!drive_en[0] |-> txd[0])
      else $error("line not idle while released");
   cover property ($fell(drive_en[0]));
   cover property (pslverr);
   cover property ($fell(txd[1]));
endmodule
bind rau_top rau_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
   .drive_en(drive_en), .rx_en(rx_en));
`default_nettype wire

// ===== verification/rau_peer.sv
// Purpose: Far-side serial node: frames out of and into one channel.
// Assumes: Called right after a rising edge; bit time in pclk cycles.
// Notes:   Line rests high between frames, as a biased pair does.
`default_nettype none
module rau_peer (
   input wire logic pclk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc = 0;
   initial line_out = 1'b1;
   always @(posedge pclk) cyc <= cyc + 1;
   // *****
   // Frame reader, sampling mid-bit
   // *****
   task automatic catch_frame(input int bitc, input int nb, input bit par,
      output logic [7:0] b, output logic p, output int t0, output bit ok);
      int n;
      n = 0;
      b = 8'h00;
      p = 1'b0;
      while (line_in !== 1'b0 && n < 30000) begin
         @(posedge pclk);
         n++;
      end
      t0 = cyc;
      repeat (bitc / 2) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         repeat (bitc) @(posedge pclk);
         b[i] = line_in;
      end
      if (par) begin
         repeat (bitc) @(posedge pclk);
         p = line_in;
      end
      repeat (bitc) @(posedge pclk);
      ok = (n < 30000) && (line_in === 1'b1);
   endtask
   // *****
   // Frame sender, eight data bits, one stop
   // *****
   // Only used on the full-duplex channel, where it sends while that node is driving
   task automatic send_frame(input int bitc, input logic [7:0] b);
      line_out <= 1'b0;
      repeat (bitc) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         line_out <= b[i];
         repeat (bitc) @(posedge pclk);
      end
      line_out <= 1'b1;
      repeat (bitc) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the two-channel direction-control port.
// Assumes: Peers model the far nodes; bus tasks wait for pready.
// Notes:   Random data from a fixed seed; framing cases from a table.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] rxd, txd, drive_en, rx_en;
   int n_mismatch = 0;
   int total_checks = 0;
   bit mon1 = 0;
   bit d1_low = 0;
   int tdiv[4] = '{1, 2, 1, 3};
   bit tq[4] = '{1, 1, 0, 1};
   int tnb[4] = '{8, 7, 5, 6};
   bit tpar[4] = '{0, 1, 1, 0};
   bit tev[4] = '{0, 1, 0, 0};
   int tst[4] = '{0, 2, 1, 3};
   rau_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
      .drive_en(drive_en), .rx_en(rx_en));
   rau_peer peer0_u (.pclk(pclk), .line_in(txd[0]), .line_out(rxd[0]));
   rau_peer peer1_u (.pclk(pclk), .line_in(txd[1]), .line_out(rxd[1]));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (mon1 && drive_en[1] !== 1'b1) d1_low <= 1'b1;
   // *****
   // Shared tasks
   // *****
   task automatic check(input bit good, input string msg);
      total_checks++;
      if (!good) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         check(0, "bus timeout");
         results();
      end
   endtask
   function automatic logic [31:0] line_word(int nb, bit par, bit ev, int st,
      bit rs, bit q, bit g);
      return 32'((nb - 5) | par << 2 | ev << 3 | st << 4 | rs << 6 | q << 7 | g << 8 | 512);
   endfunction
   // Driver falls two character times after the start edge
   function automatic int fall_cyc(int tk, int nb, bit par, int st);
      return 2 * (16 * (1 + nb + par) + (st == 0 ? 16 : st == 1 ? 24 : 32)) * tk;
   endfunction
   // *****
   // Main sequence
   // *****
   initial begin
      logic [7:0] b, got;
      logic [7:0] rb[3];
      logic [7:0] q[$];
      logic p;
      int t0, n, tk, k, exp;
      bit ok;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      void'($urandom(29482));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (150) @(posedge pclk);
      for (int c = 0; c < 2; c++) begin
         apb(0, 12'(8 + c * 32), 0);
         check(rd === 32'h203 && er === 1'b0, "line reset value");
         apb(0, 12'(4 + c * 32), 0);
         check(rd === 32'h4, "divisor reset value");
      end
      check(drive_en === 2'b11 && rx_en === 2'b11, "full duplex driver on");
      apb(0, 12'h010, 0);
      check(er === 1'b1 && rd === 32'h0, "unmapped read");
      for (int i = 0; i < 4; i++) begin
         tk = tdiv[i] * (tq[i] ? 1 : 4);
         apb(1, 12'h004, 32'(tdiv[i]));
         apb(1, 12'h008, line_word(tnb[i], tpar[i], tev[i], tst[i], 1, tq[i], 0) -
            (i == 2) * 512);
         repeat (4) @(posedge pclk);
         check(drive_en[0] === 1'b0 && rx_en[0] === 1'b1, "released when idle");
         b = 8'($urandom) & 8'((1 << tnb[i]) - 1);
         apb(1, 12'h000, {24'h0, b});
         peer0_u.catch_frame(16 * tk, tnb[i], tpar[i], got, p, t0, ok);
         check(ok && got === b, "frame data");
         if (!ok) results();
         if (tpar[i]) check(p === ((^b) ^ !tev[i]), "parity bit");
         check(drive_en[0] === 1'b1 && rx_en[0] === (i == 2), "driving, blanked");
         n = 0;
         while (drive_en[0] !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
         end
         exp = fall_cyc(tk, tnb[i], tpar[i], tst[i]);
         n = peer0_u.cyc - t0;
         check(n >= exp - 2 && n <= exp + tk + 3, "driver hold time");
         if (n >= 5000) results();
      end
      apb(1, 12'h008, line_word(8, 0, 0, 0, 1, 1, 1));
      k = 0;
      while (k < 20) begin
         apb(0, 12'h00c, 0);
         if (rd[1]) break;
         b = 8'($urandom);
         q.push_back(b);
         apb(1, 12'h000, {24'h0, b});
         k++;
      end
      check(k >= 16 && k <= 19, "transmit queue depth");
      check(txd[0] === 1'b1 && rd[3] === 1'b0, "gate blocks transmit");
      apb(1, 12'h008, line_word(8, 0, 0, 0, 1, 1, 0));
      foreach (q[j]) begin
         peer0_u.catch_frame(16 * tk, 8, 0, got, p, t0, ok);
         check(ok && got === q[j], "queued byte order");
         if (!ok) results();
      end
      apb(1, 12'h024, 32'h1);
      apb(1, 12'h028, line_word(8, 0, 0, 0, 0, 1, 0));
      mon1 <= 1'b1;
      foreach (rb[j]) rb[j] = 8'($urandom);
      b = 8'($urandom);
      fork
         foreach (rb[j]) peer1_u.send_frame(16, rb[j]);
         begin
            apb(1, 12'h020, {24'h0, b});
            peer1_u.catch_frame(16, 8, 0, got, p, t0, ok);
         end
      join
      check(ok && got === b, "full duplex transmit");
      if (!ok) results();
      repeat (40) @(posedge pclk);
      foreach (rb[j]) begin
         apb(0, 12'h020, 0);
         check(rd[7:0] === rb[j], "received byte");
      end
      check(d1_low === 1'b0, "driver stayed on");
      results();
   end
endmodule
`default_nettype wire
